//--- rtl/wdc_pkg.sv
package wdc_pkg;

    // Timing
    localparam int WDC_CLK_MHZ = 100;
    localparam int WDC_WDT_PERIOD_MS = 12;
    localparam int WDC_WDT_BASE_CYCLES = WDC_WDT_PERIOD_MS * 1000 * WDC_CLK_MHZ;
    localparam int WDC_TMR_OVF_COUNT = 65536;
    localparam int WDC_CNT_W = 21;
    localparam int WDC_PS_W = 8;

    // APB register offsets (byte addresses)
    localparam logic [7:0] WDC_OFF_CFG_WORD = 8'h00;
    localparam logic [7:0] WDC_OFF_STATUS = 8'h04;
    localparam logic [7:0] WDC_OFF_COMMAND = 8'h08;
    localparam logic [7:0] WDC_OFF_TBL_ADDR = 8'h0C;
    localparam logic [7:0] WDC_OFF_TBL_CMD = 8'h10;
    localparam logic [7:0] WDC_OFF_TBL_LATCH = 8'h14;

    // Command register bits
    localparam int WDC_CMD_CLEAR_WATCHDOG_INSTR_BIT = 0;
    localparam int WDC_CMD_SLEEP_BIT = 1;
    localparam int WDC_CMD_WAKE_BIT = 2;
    localparam int WDC_TCMD_RD_BIT = 0;
    localparam int WDC_TCMD_WR_BIT = 1;

    // Status register bits
    localparam int WDC_ST_TO_N_BIT = 0;
    localparam int WDC_ST_SLEEP_BIT = 1;
    localparam int WDC_ST_OSC_LSB = 2;
    localparam int WDC_ST_MODE_LSB = 4;
    localparam int WDC_ST_PWRT_BIT = 6;

    // Configuration word layout: bit index equals location address low nibble
    localparam logic [15:0] WDC_CFG_BASE_ADDR = 16'hFE00;
    localparam logic [15:0] WDC_CFG_HIGH_ADDR = 16'hFE08;
    localparam logic [15:0] WDC_CFG_LAST_ADDR = 16'hFE0F;
    localparam logic [15:0] WDC_CFG_RESET = 16'hFFFF;
    localparam logic [15:0] WDC_CFG_EXIST_MASK = 16'h805F;
    localparam int WDC_CFG_OSC_LSB = 0;
    localparam int WDC_CFG_WDPS_LSB = 2;
    localparam logic [7:0] WDC_TBL_HIGH_FILL = 8'hFF;

    // Postscale code: 0..8 is log2 of the ratio, anything else means plain timer
    localparam logic [3:0] WDC_PS_TIMER = 4'hF;

    typedef enum logic [1:0] {
        WDC_OSC_LF = 2'b00,
        WDC_OSC_XT = 2'b01,
        WDC_OSC_EC = 2'b10,
        WDC_OSC_RC = 2'b11
    } wdc_osc_mode_t;

    typedef enum logic [1:0] {
        WDC_MODE_OFF = 2'b00,
        WDC_MODE_WDOG = 2'b01,
        WDC_MODE_TIMER = 2'b10
    } wdc_mode_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } wdc_tbl_latch_t;

endpackage

//--- rtl/wdc_watchdog.sv
// Summary of operation
// [RQ1] Watchdog counts from its own free-running clock, not the device oscillator.
// [RQ2] Watchdog keeps counting while the device clock is stopped in sleep.
// [RQ3] Watchdog time-out requests a full device reset, awake or asleep.
// [RQ4] Watchdog configuration code 00 disables the watchdog permanently.
// [RQ5] Base period 12 ms; postscaler extends it by ratios up to 1:256.
// [RQ6] Counter and postscaler clear on reset, sleep, clear-watchdog and interrupt wake.
// [RQ7] Watchdog time-out clears the active-low time-out flag.
// [RQ8] Counting starts on the first clock edge after reset release.
// [RQ9] Counter alone serves as power-up delay timer during power-on, one base period; postscaler is bypassed.
// [RQ10] Plain timer runs on the device clock, overflowing after 65536 periods.
// [RQ11] Plain timer overflow only clears the flag; clear-watchdog sets it again.
// [RQ12] Plain timer holds its count while the device sleeps.
// [RQ13] Software cannot read or write the counter or postscaler.
// [RQ14] Configuration bits read 1 unprogrammed; any table write programs to 0.
// [RQ15] Reads of FE00h-FE07h give the config low byte, high latch FFh.
// [RQ16] Reads of FE08h-FE0Fh give the config high byte, high latch FFh.
// [RQ17] Config space mapped only in microcontroller modes; programmer reads always.
// [RQ18] Programmer writes configuration locations in ascending order from FE00h.
// [RQ19] Two oscillator bits select low-power crystal, crystal, external or RC.
// [RQ20] Mapping of non-zero watchdog codes to ratio or timer is a parameter.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module wdc_watchdog
    import wdc_pkg::*;
#(
    parameter int BASE_CYCLES = WDC_WDT_BASE_CYCLES,
    parameter logic [3:0] PS_CODE_01 = WDC_PS_TIMER,
    parameter logic [3:0] PS_CODE_10 = 4'h8,
    parameter logic [3:0] PS_CODE_11 = 4'h0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dev_clk_tick,
    input wire logic por_seq,
    input wire logic mc_mode,
    input wire logic programmer_active,
    output logic wdog_reset_req,
    output logic pwrt_expired,
    output logic timeout_flag_n,
    output logic sleep_mode,
    output wdc_osc_mode_t osc_select_cfg,
    output wdc_tbl_latch_t table_latch
);

    localparam logic [WDC_CNT_W-1:0] BASE_LAST = WDC_CNT_W'(BASE_CYCLES - 1);
    localparam logic [WDC_CNT_W-1:0] TMR_LAST = WDC_CNT_W'(WDC_TMR_OVF_COUNT - 1);

    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] tbl_addr_q;
    wdc_tbl_latch_t tbl_latch_q;
    wdc_tbl_latch_t tbl_latch_d;
    logic [WDC_CNT_W-1:0] watchdog_counter_q;
    logic [WDC_CNT_W-1:0] watchdog_counter_d;
    logic [WDC_PS_W-1:0] postscale_q;
    logic [WDC_PS_W-1:0] postscale_d;
    logic to_n_q;
    logic sleep_q;
    logic pwrt_q;
    logic rst_req_q;
    logic pready_q;
    logic [31:0] rdata_q;

    // APB decode
    wire logic apb_acc = psel & penable;
    // Writes and commands act only at the edge that completes the transfer
    wire logic apb_done = apb_acc & pready_q;
    wire logic apb_wr = apb_done & pwrite;
    wire logic apb_rd_cap = apb_acc & ~pwrite & ~pready_q;
    wire logic hit_cfg = (paddr == WDC_OFF_CFG_WORD);
    wire logic hit_status = (paddr == WDC_OFF_STATUS);
    wire logic hit_cmd = (paddr == WDC_OFF_COMMAND);
    wire logic hit_taddr = (paddr == WDC_OFF_TBL_ADDR);
    wire logic hit_tcmd = (paddr == WDC_OFF_TBL_CMD);
    wire logic hit_tlatch = (paddr == WDC_OFF_TBL_LATCH);
    wire logic hit_any = hit_cfg | hit_status | hit_cmd | hit_taddr | hit_tcmd | hit_tlatch;

    wire logic cmd_clear_watchdog_instr = apb_wr & hit_cmd & pwdata[WDC_CMD_CLEAR_WATCHDOG_INSTR_BIT];
    wire logic cmd_sleep = apb_wr & hit_cmd & pwdata[WDC_CMD_SLEEP_BIT];
    wire logic cmd_wake = apb_wr & hit_cmd & pwdata[WDC_CMD_WAKE_BIT] & sleep_q;
    wire logic table_read_instr = apb_wr & hit_tcmd & pwdata[WDC_TCMD_RD_BIT];
    wire logic table_write_instr = apb_wr & hit_tcmd & pwdata[WDC_TCMD_WR_BIT];

    // Configuration space access
    wire logic tbl_in_cfg = (tbl_addr_q >= WDC_CFG_BASE_ADDR) && (tbl_addr_q <= WDC_CFG_LAST_ADDR);
    wire logic tbl_cfg_high = (tbl_addr_q >= WDC_CFG_HIGH_ADDR);
    wire logic cfg_mapped = mc_mode | programmer_active; // RQ17
    wire logic cfg_rd = table_read_instr & tbl_in_cfg & cfg_mapped;
    wire logic cfg_wr = table_write_instr & tbl_in_cfg & cfg_mapped;
    wire logic [3:0] cfg_bit_idx = tbl_addr_q[3:0];

    // Watchdog mode selection
    wire logic [1:0] wdog_period_cfg = cfg_q[WDC_CFG_WDPS_LSB +: 2];
    wire logic [3:0] ps_code = (wdog_period_cfg == 2'b01) ? PS_CODE_01 :
                               (wdog_period_cfg == 2'b10) ? PS_CODE_10 : PS_CODE_11; // RQ20
    wire wdc_mode_t mode = (wdog_period_cfg == 2'b00) ? WDC_MODE_OFF : // RQ4
                           (ps_code > 4'h8) ? WDC_MODE_TIMER : WDC_MODE_WDOG;
    wire logic [WDC_PS_W:0] ps_ratio = (WDC_PS_W + 1)'(1) << ps_code[3:0];
    wire logic [WDC_PS_W-1:0] ps_last = WDC_PS_W'(ps_ratio - (WDC_PS_W + 1)'(1)); // RQ5

    // Counting conditions
    wire logic as_pwrt = por_seq & ~pwrt_q; // RQ9
    wire logic wdog_run = as_pwrt | (mode == WDC_MODE_WDOG); // RQ1 RQ2
    wire logic tmr_run = ~por_seq & (mode == WDC_MODE_TIMER) & dev_clk_tick & ~sleep_q; // RQ10 RQ12
    wire logic base_wrap = wdog_run & (watchdog_counter_q == BASE_LAST);
    wire logic ps_done = as_pwrt ? 1'b1 : (postscale_q == ps_last);
    wire logic wdog_expire = base_wrap & ps_done;
    wire logic wdog_timeout = wdog_expire & ~por_seq; // RQ3
    wire logic pwrt_fire = wdog_expire & as_pwrt;
    wire logic tmr_ovf = tmr_run & (watchdog_counter_q == TMR_LAST); // RQ10
    wire logic clr_cnt = cmd_clear_watchdog_instr | cmd_sleep | cmd_wake | wdog_timeout; // RQ6

    always_comb begin
        watchdog_counter_d = watchdog_counter_q;
        postscale_d = postscale_q;
        if (clr_cnt) begin
            watchdog_counter_d = '0; // RQ6
            postscale_d = '0; // RQ6
        end else if (wdog_run) begin
            if (base_wrap) begin
                watchdog_counter_d = '0;
                postscale_d = ps_done ? '0 : postscale_q + WDC_PS_W'(1); // RQ5
            end else begin
                watchdog_counter_d = watchdog_counter_q + WDC_CNT_W'(1); // RQ2
            end
        end else if (tmr_run) begin
            watchdog_counter_d = tmr_ovf ? '0 : watchdog_counter_q + WDC_CNT_W'(1); // RQ10
        end else if (mode == WDC_MODE_OFF) begin
            watchdog_counter_d = '0; // RQ4
            postscale_d = '0;
        end
    end

    // Counter starts from zero on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter_q <= '0; // RQ6 RQ8
            postscale_q <= '0;
        end else begin
            watchdog_counter_q <= watchdog_counter_d; // RQ8
            postscale_q <= postscale_d;
        end
    end

    // Time-out flag: hardware clear wins over the clear-watchdog set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_n_q <= 1'b1;
        end else if (wdog_timeout || tmr_ovf) begin
            to_n_q <= 1'b0; // RQ7 RQ11
        end else if (cmd_clear_watchdog_instr) begin
            to_n_q <= 1'b1; // RQ11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_q <= 1'b0;
            rst_req_q <= 1'b0;
            pwrt_q <= 1'b0;
        end else begin
            sleep_q <= (sleep_q | cmd_sleep) & ~cmd_wake & ~wdog_timeout;
            rst_req_q <= wdog_timeout; // RQ3
            pwrt_q <= por_seq & (pwrt_q | pwrt_fire); // RQ9
        end
    end

    // Configuration fuses: a write programs the addressed bit whatever the data
    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr && WDC_CFG_EXIST_MASK[cfg_bit_idx]) begin
            cfg_d[cfg_bit_idx] = 1'b0; // RQ14
        end
    end

    always_comb begin
        tbl_latch_d = tbl_latch_q;
        if (cfg_rd) begin
            tbl_latch_d.high = WDC_TBL_HIGH_FILL; // RQ15 RQ16
            tbl_latch_d.low = tbl_cfg_high ? cfg_q[15:8] : cfg_q[7:0]; // RQ15 RQ16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= WDC_CFG_RESET; // RQ14
            tbl_addr_q <= '0;
            tbl_latch_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            tbl_latch_q <= tbl_latch_d;
            if (apb_wr && hit_taddr) begin
                tbl_addr_q <= pwdata[15:0];
            end
        end
    end

    // Read data; counter and postscaler have no software path
    wire logic [31:0] status_word = {25'h0000000, pwrt_q, 2'(mode), 2'(osc_select_cfg), sleep_q, to_n_q};
    wire logic [31:0] rd_mux = hit_cfg ? {16'h0000, cfg_q} : // RQ13
                               hit_status ? status_word :
                               hit_taddr ? {16'h0000, tbl_addr_q} :
                               hit_tlatch ? {16'h0000, tbl_latch_q} : 32'h00000000;

    // One wait state so that read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            pready_q <= apb_acc & ~pready_q;
            rdata_q <= apb_rd_cap ? rd_mux : 32'h00000000; // RQ13
        end
    end

    assign prdata = rdata_q;
    assign pready = pready_q;
    assign pslverr = apb_done & ~hit_any;
    assign osc_select_cfg = wdc_osc_mode_t'(cfg_q[WDC_CFG_OSC_LSB +: 2]); // RQ19
    assign wdog_reset_req = rst_req_q;
    assign pwrt_expired = pwrt_q;
    assign timeout_flag_n = to_n_q;
    assign sleep_mode = sleep_q;
    assign table_latch = tbl_latch_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_timeout_resets;
        wdog_timeout |=> wdog_reset_req && !timeout_flag_n && watchdog_counter_q == '0;
    endproperty
    a_timeout_resets: assert property (p_timeout_resets) else $error("time-out did not reset"); // RQ3

    property p_off_never_fires;
        (mode == WDC_MODE_OFF && !por_seq) |=> !wdog_reset_req && watchdog_counter_q == '0;
    endproperty
    a_off_never_fires: assert property (p_off_never_fires) else $error("disabled watchdog fired"); // RQ4

    property p_clear_actions;
        (cmd_clear_watchdog_instr || cmd_sleep || cmd_wake) |=> watchdog_counter_q == '0 && postscale_q == '0;
    endproperty
    a_clear_actions: assert property (p_clear_actions) else $error("clear action missed"); // RQ6

    property p_counts_in_sleep;
        (mode == WDC_MODE_WDOG && sleep_q && !clr_cnt && !base_wrap)
            |=> watchdog_counter_q == $past(watchdog_counter_q) + WDC_CNT_W'(1);
    endproperty
    a_counts_in_sleep: assert property (p_counts_in_sleep) else $error("watchdog stalled in sleep"); // RQ2

    property p_timer_holds_sleep;
        (mode == WDC_MODE_TIMER && sleep_q && !clr_cnt && !por_seq) |=> $stable(watchdog_counter_q);
    endproperty
    a_timer_holds_sleep: assert property (p_timer_holds_sleep) else $error("timer moved in sleep"); // RQ12

    property p_timer_no_reset;
        (mode == WDC_MODE_TIMER && !por_seq) |=> !wdog_reset_req;
    endproperty
    a_timer_no_reset: assert property (p_timer_no_reset) else $error("timer mode reset device"); // RQ11

    property p_timer_ovf_flag;
        tmr_ovf |=> !timeout_flag_n && watchdog_counter_q == '0;
    endproperty
    a_timer_ovf_flag: assert property (p_timer_ovf_flag) else $error("timer overflow flag wrong"); // RQ10

    property p_clear_watchdog_instr_sets_flag;
        (cmd_clear_watchdog_instr && !wdog_timeout && !tmr_ovf) |=> timeout_flag_n;
    endproperty
    a_clear_watchdog_instr_sets_flag: assert property (p_clear_watchdog_instr_sets_flag) else $error("flag not set by clear"); // RQ11

    property p_cfg_only_clears;
        ##1 (cfg_q & ~$past(cfg_q)) == 16'h0000;
    endproperty
    a_cfg_only_clears: assert property (p_cfg_only_clears) else $error("config bit unprogrammed"); // RQ14

    property p_tbl_read;
        cfg_rd |=> table_latch.high == WDC_TBL_HIGH_FILL
            && table_latch.low == ($past(tbl_cfg_high) ? $past(cfg_q[15:8]) : $past(cfg_q[7:0]));
    endproperty
    a_tbl_read: assert property (p_tbl_read) else $error("table read data wrong"); // RQ15 RQ16

    property p_unmapped_ignored;
        (table_write_instr && !cfg_mapped) |=> $stable(cfg_q);
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) else $error("unmapped write took effect"); // RQ17

    property p_pwrt_done;
        pwrt_fire |=> pwrt_expired && !wdog_reset_req;
    endproperty
    a_pwrt_done: assert property (p_pwrt_done) else $error("power-up delay not flagged"); // RQ9

    // The master holds the access phase, so the answer follows one cycle later
    property p_apb_one_wait;
        (apb_acc && !pready_q) |=> pready;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("access phase not answered"); // RQ13

    property p_tmr_counts;
        (tmr_run && !tmr_ovf && !clr_cnt)
            |=> watchdog_counter_q == $past(watchdog_counter_q) + WDC_CNT_W'(1);
    endproperty
    a_tmr_counts: assert property (p_tmr_counts) else $error("timer missed a tick"); // RQ10

    property p_timer_needs_tick;
        (mode == WDC_MODE_TIMER && !dev_clk_tick && !clr_cnt && !por_seq) |=> $stable(watchdog_counter_q);
    endproperty
    a_timer_needs_tick: assert property (p_timer_needs_tick) else $error("timer moved without tick"); // RQ10

    property p_sleep_entry;
        (cmd_sleep && !cmd_wake && !wdog_timeout) |=> sleep_mode && postscale_q == '0;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry not cleared"); // RQ6

    property p_por_no_reset;
        por_seq |=> !wdog_reset_req;
    endproperty
    a_por_no_reset: assert property (p_por_no_reset) else $error("reset during power-up"); // RQ9

    property p_pwrt_holds;
        (pwrt_expired && por_seq) |=> pwrt_expired;
    endproperty
    a_pwrt_holds: assert property (p_pwrt_holds) else $error("power-up flag dropped"); // RQ9

    property p_ps_steps;
        (wdog_run && base_wrap && !ps_done && !clr_cnt)
            |=> postscale_q == $past(postscale_q) + WDC_PS_W'(1);
    endproperty
    a_ps_steps: assert property (p_ps_steps) else $error("postscaler did not step"); // RQ5

    property p_reset_pulse;
        wdog_reset_req |=> !wdog_reset_req;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset request too long"); // RQ3

    property p_timeout_wakes;
        wdog_timeout |=> !sleep_mode;
    endproperty
    a_timeout_wakes: assert property (p_timeout_wakes) else $error("time-out left device asleep"); // RQ3

    // Fuses change only through a table write
    property p_cfg_stable;
        !cfg_wr |=> $stable(cfg_q);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without write"); // RQ14

    property p_cfg_write_programs;
        (cfg_wr && WDC_CFG_EXIST_MASK[cfg_bit_idx]) |=> !cfg_q[$past(cfg_bit_idx)];
    endproperty
    a_cfg_write_programs: assert property (p_cfg_write_programs) else $error("config bit not programmed"); // RQ14

    property p_tbl_write_no_latch;
        (table_write_instr && !table_read_instr) |=> $stable(table_latch);
    endproperty
    a_tbl_write_no_latch: assert property (p_tbl_write_no_latch) else $error("table write moved latch"); // RQ14

    property p_unmapped_read;
        (table_read_instr && !cfg_mapped) |=> $stable(table_latch);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read took effect"); // RQ17

    c_wdog_timeout: cover property (wdog_timeout);
    c_timer_ovf: cover property (tmr_ovf);
    c_pwrt: cover property (pwrt_fire);
    c_cfg_prog: cover property (cfg_wr ##1 cfg_rd);
    c_timer_sleep: cover property (mode == WDC_MODE_TIMER && sleep_q);

endmodule // wdc_watchdog

`default_nettype wire

//--- testbench/watchdog_with_config_fuses_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module watchdog_with_config_fuses_tb_top;
    import wdc_pkg::*;

    localparam logic [31:0] CMD_CLR = 32'h0000_0001 << WDC_CMD_CLEAR_WATCHDOG_INSTR_BIT;
    localparam logic [31:0] CMD_SLP = 32'h0000_0001 << WDC_CMD_SLEEP_BIT;
    localparam logic [31:0] CMD_WAKE = 32'h0000_0001 << WDC_CMD_WAKE_BIT;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic dev_clk_tick = 1'b0;
    logic por_seq = 1'b0;
    logic mc_mode = 1'b1;
    logic programmer_active = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdog_reset_req;
    logic pwrt_expired;
    logic timeout_flag_n;
    logic sleep_mode;
    wdc_osc_mode_t osc_select_cfg;
    wdc_tbl_latch_t table_latch;
    int errors = 0;
    int compares = 0;
    int pulses = 0;
    logic [31:0] rd;
    logic er;

    // Short base period keeps the 1:256 case within the run budget
    wdc_watchdog #(.BASE_CYCLES(16), .PS_CODE_01(4'hF), .PS_CODE_10(4'h8), .PS_CODE_11(4'h0)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dev_clk_tick(dev_clk_tick), .por_seq(por_seq), .mc_mode(mc_mode),
        .programmer_active(programmer_active), .wdog_reset_req(wdog_reset_req),
        .pwrt_expired(pwrt_expired), .timeout_flag_n(timeout_flag_n), .sleep_mode(sleep_mode),
        .osc_select_cfg(osc_select_cfg), .table_latch(table_latch)
    );

    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        if (wdog_reset_req === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    task final_report;
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task tbl(input logic [15:0] a, input int bitn);
        apb(1'b1, WDC_OFF_TBL_ADDR, {16'h0000, a});
        apb(1'b1, WDC_OFF_TBL_CMD, 32'h0000_0001 << bitn);
    endtask

    task wait_pulse(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (wdog_reset_req !== 1'b1 && n < 10000);
    endtask

    task do_reset(input logic por);
        @(posedge pclk);
        presetn <= 1'b0;
        por_seq <= por;
        mc_mode <= 1'b1;
        programmer_active <= 1'b0;
        dev_clk_tick <= 1'b0;
        repeat (16) @(posedge pclk);
        check({29'h0, timeout_flag_n, osc_select_cfg}, 32'h0000_0007);
        check({16'h0000, table_latch}, 32'h0000_0000);
        presetn <= 1'b1;
    endtask

    task t_regs;
        do_reset(1'b0);
        apb(1'b0, WDC_OFF_CFG_WORD, 32'h0000_0000);
        check(rd, 32'h0000_FFFF);
        apb(1'b0, WDC_OFF_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_001D);
        apb(1'b1, 8'h18, 32'h0000_00FF);
        check({31'h0, er}, 32'h0000_0001);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check(rd, 32'h0000_0000);
    endtask

    task t_clear;
        int n;
        int p;
        wait_pulse(n);
        @(negedge pclk);
        check({31'h0, timeout_flag_n}, 32'h0000_0000);
        apb(1'b1, WDC_OFF_COMMAND, CMD_CLR);
        @(negedge pclk);
        check({31'h0, timeout_flag_n}, 32'h0000_0001);
        p = pulses;
        repeat (5) begin
            apb(1'b1, WDC_OFF_COMMAND, CMD_CLR);
            repeat (10) @(posedge pclk);
        end
        check(pulses - p, 0);
        apb(1'b1, WDC_OFF_COMMAND, CMD_CLR);
        wait_pulse(n);
        check(n, 17);
        wait_pulse(n);
        check(n, 16);
        apb(1'b1, WDC_OFF_COMMAND, CMD_SLP);
        @(negedge pclk);
        check({31'h0, sleep_mode}, 32'h0000_0001);
        wait_pulse(n);
        check(n, 17);
        apb(1'b1, WDC_OFF_COMMAND, CMD_SLP);
        repeat (8) @(posedge pclk);
        apb(1'b1, WDC_OFF_COMMAND, CMD_WAKE);
        wait_pulse(n);
        check(n, 17);
    endtask

    task t_fuses;
        int p;
        for (int k = 3; k >= 0; k--) begin
            do_reset(1'b0);
            // Locations go in ascending order; the base address FE00h is skipped when k[0] is 1
            if (k[0] == 1'b0) tbl(WDC_CFG_BASE_ADDR, WDC_TCMD_WR_BIT);
            if (k[1] == 1'b0) tbl(16'hFE01, WDC_TCMD_WR_BIT);
            @(negedge pclk);
            check({30'h0, osc_select_cfg}, k);
        end
        tbl(16'hFE02, WDC_TCMD_WR_BIT);
        tbl(16'hFE03, WDC_TCMD_WR_BIT);
        tbl(16'hFE05, WDC_TCMD_WR_BIT);
        apb(1'b0, WDC_OFF_CFG_WORD, 32'h0000_0000);
        check(rd, 32'h0000_FFF0);
        p = pulses;
        repeat (100) @(posedge pclk);
        check(pulses - p, 0);
        tbl(16'hFE07, WDC_TCMD_RD_BIT);
        apb(1'b0, WDC_OFF_TBL_LATCH, 32'h0000_0000);
        check(rd, 32'h0000_FFF0);
        check({16'h0000, table_latch}, 32'h0000_FFF0);
        tbl(WDC_CFG_HIGH_ADDR, WDC_TCMD_RD_BIT);
        apb(1'b0, WDC_OFF_TBL_LATCH, 32'h0000_0000);
        check(rd, 32'h0000_FFFF);
        mc_mode <= 1'b0;
        tbl(WDC_CFG_BASE_ADDR, WDC_TCMD_RD_BIT);
        apb(1'b0, WDC_OFF_TBL_LATCH, 32'h0000_0000);
        check(rd, 32'h0000_FFFF);
        programmer_active <= 1'b1;
        tbl(WDC_CFG_BASE_ADDR, WDC_TCMD_RD_BIT);
        apb(1'b0, WDC_OFF_TBL_LATCH, 32'h0000_0000);
        check(rd, 32'h0000_FFF0);
    endtask

    task t_ps;
        int n;
        do_reset(1'b0);
        tbl(16'hFE02, WDC_TCMD_WR_BIT);
        wait_pulse(n);
        wait_pulse(n);
        check(n, 4096);
    endtask

    task t_timer;
        int p;
        do_reset(1'b0);
        tbl(16'hFE03, WDC_TCMD_WR_BIT);
        apb(1'b0, WDC_OFF_STATUS, 32'h0000_0000);
        check(rd & 32'h0000_0030, 32'h0000_0020);
        p = pulses;
        apb(1'b1, WDC_OFF_COMMAND, CMD_CLR);
        dev_clk_tick <= 1'b1;
        repeat (65530) @(posedge pclk);
        check({31'h0, timeout_flag_n}, 32'h0000_0001);
        repeat (10) @(posedge pclk);
        check({31'h0, timeout_flag_n}, 32'h0000_0000);
        check(pulses - p, 0);
        dev_clk_tick <= 1'b0;
        apb(1'b1, WDC_OFF_COMMAND, CMD_CLR);
        @(negedge pclk);
        check({31'h0, timeout_flag_n}, 32'h0000_0001);
        // Ticks keep coming while asleep; the timer must hold
        apb(1'b1, WDC_OFF_COMMAND, CMD_SLP);
        dev_clk_tick <= 1'b1;
        repeat (20) @(posedge pclk);
        check({30'h0, sleep_mode, timeout_flag_n}, 32'h0000_0003);
    endtask

    task t_por;
        int p;
        p = pulses;
        do_reset(1'b1);
        repeat (10) @(posedge pclk);
        check({31'h0, pwrt_expired}, 32'h0000_0000);
        repeat (10) @(posedge pclk);
        check({31'h0, pwrt_expired}, 32'h0000_0001);
        check(pulses - p, 0);
        por_seq <= 1'b0;
        repeat (2) @(posedge pclk);
        check({31'h0, pwrt_expired}, 32'h0000_0000);
    endtask

    initial begin
        t_regs;
        t_clear;
        t_fuses;
        t_ps;
        t_timer;
        t_por;
        final_report;
    end

    initial begin
        #950000;
        errors++;
        final_report;
    end
endmodule // watchdog_with_config_fuses_tb_top

`default_nettype wire
